//--- hw/fwp_pkg.sv
// Purpose: constants and types for the flash write-protection block
// Assumes: mclk at 125 MHz; 25-bit byte address into a 32MB array
// Notes:   non-volatile bits load their reset values at power-up (sys_rst)
package fwp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ     = 125;
  localparam int SRW_TIME_NS = 2000;
  localparam int SRW_CYCLES  = (SRW_TIME_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // serial frame and array geometry
  // ----------------------------------------------------------------
  localparam logic [2:0] FRAME_BYTES = 3'h5;
  localparam int         ADDR_W      = 25;
  localparam int         BLK_LSB     = 16;
  localparam int         BLK_W       = 9;
  localparam logic [3:0] PROT_MAX    = 4'h9;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_WRITE_ENABLE_CMD_EN   = 8'h06;
  localparam logic [7:0] OPC_WR_DIS    = 8'h04;
  localparam logic [7:0] OPC_RD_SR1    = 8'h05;
  localparam logic [7:0] OPC_RD_SR2    = 8'h35;
  localparam logic [7:0] OPC_RD_SR3    = 8'h15;
  localparam logic [7:0] OPC_WR_SR1    = 8'h01;
  localparam logic [7:0] OPC_WR_SR2    = 8'h31;
  localparam logic [7:0] OPC_WR_SR3    = 8'h11;
  localparam logic [7:0] OPC_PROG      = 8'h02;
  localparam logic [7:0] OPC_SECT      = 8'h20;
  localparam logic [7:0] OPC_BLK64     = 8'hd8;
  localparam logic [7:0] OPC_BLK32     = 8'h52;
  localparam logic [7:0] OPC_CHIP_A    = 8'hc7;
  localparam logic [7:0] OPC_CHIP_B    = 8'h60;
  localparam logic [7:0] OPC_SLEEP     = 8'hb9;
  localparam logic [7:0] OPC_WAKE      = 8'hab;
  localparam logic [7:0] OPC_RST_EN    = 8'h66;
  localparam logic [7:0] OPC_RST_GO    = 8'h99;
  localparam logic [7:0] OPC_SUSPEND   = 8'h75;
  localparam logic [7:0] OPC_RESUME    = 8'h7a;
  localparam logic [7:0] OPC_ADDR4_ON  = 8'hb7;
  localparam logic [7:0] OPC_ADDR4_OFF = 8'he9;

  // ----------------------------------------------------------------
  // status field positions, each within its own byte
  // ----------------------------------------------------------------
  localparam int SR1_STATUS_LOCK_LOW = 7;
  localparam int SR1_BPH  = 6;
  localparam int SR1_BPL  = 2;
  localparam int SR2_STATUS_LOCK_HIGH = 6;
  localparam int SR2_LBH  = 5;
  localparam int SR2_LBL  = 3;
  localparam int SR2_QE   = 1;
  localparam int SR3_HR   = 7;
  localparam int SR3_DRVH = 6;
  localparam int SR3_DRVL = 5;
  localparam int SR3_ADP  = 4;
  localparam int SR3_DCH  = 1;
  localparam int SR3_DCL  = 0;

  // ----------------------------------------------------------------
  // power-up values of the non-volatile bits
  // ----------------------------------------------------------------
  localparam logic [4:0] RST_BP   = 5'h00;
  localparam logic [1:0] RST_SRP  = 2'h0;
  localparam logic [2:0] RST_LB   = 3'h0;
  localparam logic       RST_QE   = 1'b0;
  localparam logic       RST_HR   = 1'b0;
  localparam logic [1:0] RST_DRV  = 2'h1;
  localparam logic       RST_ADP  = 1'b0;
  localparam logic [1:0] RST_DC   = 2'h0;

  // ----------------------------------------------------------------
  // array operation kinds and core states
  // ----------------------------------------------------------------
  localparam logic [2:0] KIND_PROG  = 3'h0;
  localparam logic [2:0] KIND_SECT  = 3'h1;
  localparam logic [2:0] KIND_BLK64 = 3'h2;
  localparam logic [2:0] KIND_BLK32 = 3'h3;
  localparam logic [2:0] KIND_CHIP  = 3'h4;

  typedef enum logic [3:0] {
    OP_IDLE  = 4'b0001,
    OP_SRW   = 4'b0010,
    OP_PROG  = 4'b0100,
    OP_ERASE = 4'b1000
  } fwp_op_e;

  typedef struct packed {
    logic [2:0] bitcnt;
    logic [2:0] bytecnt;
  } fwp_cnt_s;

  typedef struct packed {
    logic [6:0]      shift;
    logic [2:0]      nbytes;
    logic [4:0][7:0] bytes;
  } fwp_buf_s;

endpackage : fwp_pkg

//--- hw/fwp_link_if.sv
// Purpose: carries a captured serial frame and the status snapshot
// Assumes: frame words are stable while chip select is high
// Notes:   status snapshot only changes while chip select is high
`timescale 1ns/1ps
interface fwp_link_if;
  logic [4:0][7:0] bytes;
  logic [2:0]      nbytes;
  logic [23:0]     status;
  logic            asleep;

  modport rx   (output bytes, output nbytes, input status, input asleep);
  modport core (input bytes, input nbytes, output status, output asleep);
endinterface : fwp_link_if

//--- hw/fwp_serial_rx.sv
// Purpose: serial front end on the link clock: shifts in bytes, shifts out status
// Assumes: mode 0/3 link, data in on rising, out on falling edge of sclk
// Notes:   chip select high clears the bit and byte counters asynchronously
`timescale 1ns/1ps
module fwp_serial_rx
  import fwp_pkg::*;
(
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic sys_rst,
  input  wire logic si,
  output logic      so_out,
  output logic      so_oe_n,
  fwp_link_if.rx    link
);

  fwp_cnt_s   c;
  fwp_cnt_s   next_c;
  fwp_buf_s   b;
  fwp_buf_s   next_b;
  logic [7:0] byte_val;
  logic [7:0] sel_byte;
  logic       rd_status;

  // ----------------------------------------------------------------
  // shift register and byte capture
  // ----------------------------------------------------------------
  always_comb begin
    next_c   = c;
    next_b   = b;
    byte_val = {b.shift, si};
    if (c.bitcnt == 3'h0 && c.bytecnt == 3'h0) begin
      next_b.nbytes = 3'h0;
    end
    next_b.shift  = byte_val[6:0];
    next_c.bitcnt = c.bitcnt + 3'h1;
    if (c.bitcnt == 3'h7 && c.bytecnt < FRAME_BYTES) begin
      next_b.bytes[c.bytecnt] = byte_val;
      next_b.nbytes           = c.bytecnt + 3'h1;
      next_c.bytecnt          = c.bytecnt + 3'h1;
    end
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end

  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      b <= '0;
    end else begin
      b <= next_b;
    end
  end

  assign link.bytes  = b.bytes;
  assign link.nbytes = b.nbytes;

  // ----------------------------------------------------------------
  // status read-out, ignored while asleep
  // ----------------------------------------------------------------
  always_comb begin
    rd_status = 1'b0;
    sel_byte  = link.status[7:0];
    if (c.bytecnt != 3'h0 && !link.asleep) begin
      if (b.bytes[0] == OPC_RD_SR1) begin
        rd_status = 1'b1;
      end else if (b.bytes[0] == OPC_RD_SR2) begin
        rd_status = 1'b1;
        sel_byte  = link.status[15:8];
      end else if (b.bytes[0] == OPC_RD_SR3) begin
        rd_status = 1'b1;
        sel_byte  = link.status[23:16];
      end
    end
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      so_out  <= 1'b0;
      so_oe_n <= 1'b1;
    end else begin
      so_out  <= sel_byte[~c.bitcnt];
      so_oe_n <= !rd_status;
    end
  end

endmodule : fwp_serial_rx

//--- hw/fwp_top.sv
// Purpose: write-enable latch, block protection and status registers of a serial flash
// Assumes: frames are decoded when chip select rises; array engine on mclk
// Notes:   host keeps chip select high at least 6 mclk cycles between frames
//
// Overview of operation
// - write enable command sets the write-enable latch
// - power-up and the two-command software reset clear the latch
// - write disable, status write, program and erases clear the latch
// - protected region stays readable; program and erase into it refused
// - write-protect pin low in hardware mode blocks protect and lock bits
// - in deep power-down only wake-up and software reset are obeyed
// - low four protect bits zero means nothing protected
// - side bit 0: codes 1 to 9 protect upper 64KB doubling to 16MB
// - side bit 1: codes 1 to 9 protect lower 64KB doubling to 16MB
// - size bits 3,2,1 = 110 or bits 3 and 1 set protect all
// - first status byte: lock low, protect bits, latch, busy
// - second status byte: suspend, lock high, security locks, quad, address mode
// - third status byte: pin function, drive, power-up mode, errors, dummy cfg
// - security lock bits once set clear only at power-up
// - latch clear rejects status write, program and erase
// - lock bits decode software, pin and power-cycle locking; lock high set locks until power-up
// - busy flag high during status write, and during program or erase while not suspended
`timescale 1ns/1ps
module fwp_top
  import fwp_pkg::*;
#(
  parameter int SRW_WAIT = SRW_CYCLES
) (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              si,
  input  wire logic              wp_n,
  input  wire logic              rst_pin_n,
  input  wire logic              array_done,
  input  wire logic              array_fail,
  output logic                   so_out,
  output logic                   so_oe_n,
  output logic                   array_start,
  output logic [2:0]             array_kind,
  output logic [ADDR_W-1:0]      array_addr,
  output logic                   array_suspend
);

  typedef struct packed {
    logic [2:0]        cs_sync;
    logic [1:0]        wp_sync;
    logic [1:0]        rp_sync;
    logic              status_lock_low;
    logic [4:0]        bp;
    logic              write_enable_latch;
    logic              status_lock_high;
    logic [2:0]        lb;
    logic              qe;
    logic              address_mode_flag;
    logic              sus_e;
    logic              sus_p;
    logic              susp;
    logic              hold_rst;
    logic [1:0]        drv;
    logic              powerup_address_mode;
    logic              ee;
    logic              pe;
    logic [1:0]        dc;
    logic              asleep;
    logic              rst_armed;
    fwp_op_e           op;
    logic [15:0]       wait_cnt;
    logic [23:0]       snap;
    logic              start;
    logic [2:0]        kind;
    logic [ADDR_W-1:0] addr;
  } fwp_core_s;

  fwp_core_s   s;
  fwp_core_s   next_s;
  fwp_link_if  link ();

  logic [7:0]        opc;
  logic [7:0]        arg;
  logic [7:0]        arg_sr2;
  logic              frame_end;
  logic              busy;
  logic              locked;
  logic              need_addr;
  logic [2:0]        alen;
  logic [ADDR_W-1:0] tgt;
  logic              hit;
  logic [7:0]        sr1;
  logic [7:0]        sr2;
  logic [7:0]        sr3;

  // ----------------------------------------------------------------
  // serial front end on the link clock
  // ----------------------------------------------------------------
  fwp_serial_rx u_rx (
    .sclk    (sclk),
    .cs_n    (cs_n),
    .sys_rst (sys_rst),
    .si      (si),
    .so_out  (so_out),
    .so_oe_n (so_oe_n),
    .link    (link.rx)
  );

  // ----------------------------------------------------------------
  // protected-region test
  // ----------------------------------------------------------------
  function automatic logic prot_hit(input logic [4:0] bp, input logic [BLK_W-1:0] blk);
    logic [BLK_W-1:0] span;
    logic             hitv;
    span = '0;
    hitv = 1'b0;
    if (bp[3:0] == 4'h0) begin
      hitv = 1'b0;
    end else if ((bp[3:1] == 3'b110) || (bp[3] && bp[1])) begin
      hitv = 1'b1;
    end else if (bp[3:0] <= PROT_MAX) begin
      span = BLK_W'(1) << (bp[3:0] - 4'h1);
      if (bp[4]) begin
        hitv = (blk < span);
      end else begin
        hitv = (blk >= BLK_W'(0) - span);
      end
    end
    return hitv;
  endfunction : prot_hit

  // ----------------------------------------------------------------
  // status bytes
  // ----------------------------------------------------------------
  always_comb begin
    busy = (s.op != OP_IDLE) && !(s.sus_e || s.sus_p);
    sr1  = {s.status_lock_low, s.bp, s.write_enable_latch, busy};
    sr2  = {s.sus_e, s.status_lock_high, s.lb, s.sus_p, s.qe, s.address_mode_flag};
    sr3  = {s.hold_rst, s.drv, s.powerup_address_mode, s.ee, s.pe, s.dc};
  end

  assign link.status = s.snap;
  assign link.asleep = s.asleep;

  // ----------------------------------------------------------------
  // frame decode
  // ----------------------------------------------------------------
  always_comb begin
    opc       = link.bytes[0];
    arg       = link.bytes[1];
    arg_sr2   = (opc == OPC_WR_SR1) ? link.bytes[2] : link.bytes[1];
    frame_end = s.cs_sync[1] && !s.cs_sync[2];
    // pin lock applies only while the pin still has its protect function
    locked    = s.status_lock_high || (s.status_lock_low && !s.wp_sync[1] && !s.qe);
    alen      = s.address_mode_flag ? 3'h4 : 3'h3;
    need_addr = (link.nbytes > alen);
    if (s.address_mode_flag) begin
      tgt = {link.bytes[1][0], link.bytes[2], link.bytes[3], link.bytes[4]};
    end else begin
      tgt = {1'b0, link.bytes[1], link.bytes[2], link.bytes[3]};
    end
    hit = prot_hit(s.bp, tgt[BLK_LSB +: BLK_W]);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s         = s;
    next_s.cs_sync = {s.cs_sync[1:0], cs_n};
    next_s.wp_sync = {s.wp_sync[0], wp_n};
    next_s.rp_sync = {s.rp_sync[0], rst_pin_n};
    next_s.start   = 1'b0;
    if (s.cs_sync[1]) begin
      next_s.snap = {sr3, sr2, sr1};
    end

    // array engine progress and status-write timer
    unique case (s.op)
      OP_IDLE: begin
      end
      OP_SRW: begin
        if (s.wait_cnt == 16'h0000) begin
          next_s.op = OP_IDLE;
        end else begin
          next_s.wait_cnt = s.wait_cnt - 16'h0001;
        end
      end
      OP_PROG, OP_ERASE: begin
        if (array_done) begin
          next_s.op = OP_IDLE;
          if (array_fail && s.op == OP_PROG) begin
            next_s.pe = 1'b1;
          end
          if (array_fail && s.op == OP_ERASE) begin
            next_s.ee = 1'b1;
          end
        end
      end
    endcase

    if (frame_end && link.nbytes != 3'h0) begin
      next_s.rst_armed = (opc == OPC_RST_EN);
      if (opc == OPC_RST_GO && s.rst_armed) begin
        // software reset: volatile bits to power-up state
        next_s.write_enable_latch    = 1'b0;
        next_s.sus_e  = 1'b0;
        next_s.sus_p  = 1'b0;
        next_s.pe     = 1'b0;
        next_s.ee     = 1'b0;
        next_s.address_mode_flag    = s.powerup_address_mode;
        next_s.asleep = 1'b0;
        next_s.op     = OP_IDLE;
      end else if (s.asleep) begin
        if (opc == OPC_WAKE) begin
          next_s.asleep = 1'b0;
        end
      end else if (busy) begin
        if (opc == OPC_SUSPEND && s.op == OP_PROG) begin
          next_s.sus_p = 1'b1;
        end
        if (opc == OPC_SUSPEND && s.op == OP_ERASE) begin
          next_s.sus_e = 1'b1;
        end
      end else begin
        unique case (opc)
          OPC_WRITE_ENABLE_CMD_EN: begin
            next_s.write_enable_latch = 1'b1;
          end
          OPC_WR_DIS: begin
            next_s.write_enable_latch = 1'b0;
          end
          OPC_SLEEP: begin
            next_s.asleep = 1'b1;
          end
          OPC_ADDR4_ON: begin
            next_s.address_mode_flag = 1'b1;
          end
          OPC_ADDR4_OFF: begin
            next_s.address_mode_flag = 1'b0;
          end
          OPC_RESUME: begin
            if (s.sus_e || s.sus_p) begin
              next_s.sus_e = 1'b0;
              next_s.sus_p = 1'b0;
              next_s.pe    = array_done && array_fail && s.op == OP_PROG;
              next_s.ee    = array_done && array_fail && s.op == OP_ERASE;
            end
          end
          OPC_WR_SR1, OPC_WR_SR2, OPC_WR_SR3: begin
            if (s.write_enable_latch && link.nbytes >= 3'h2 && s.op == OP_IDLE) begin
              next_s.write_enable_latch = 1'b0;
              if (!locked) begin
                next_s.op       = OP_SRW;
                next_s.wait_cnt = 16'(SRW_WAIT - 1);
                if (opc == OPC_WR_SR1) begin
                  next_s.status_lock_low = arg[SR1_STATUS_LOCK_LOW];
                  next_s.bp   = arg[SR1_BPH:SR1_BPL];
                end
                if (opc == OPC_WR_SR2 || (opc == OPC_WR_SR1 && link.nbytes >= 3'h3)) begin
                  // suspend and address-mode bits are internal only
                  next_s.status_lock_high = arg_sr2[SR2_STATUS_LOCK_HIGH];
                  next_s.lb   = s.lb | arg_sr2[SR2_LBH:SR2_LBL];
                  next_s.qe   = arg_sr2[SR2_QE];
                end
                if (opc == OPC_WR_SR3) begin
                  // error bits are internal only
                  next_s.hold_rst = arg[SR3_HR];
                  next_s.drv      = arg[SR3_DRVH:SR3_DRVL];
                  next_s.powerup_address_mode      = arg[SR3_ADP];
                  next_s.dc       = arg[SR3_DCH:SR3_DCL];
                end
              end
            end
          end
          OPC_PROG, OPC_SECT, OPC_BLK64, OPC_BLK32, OPC_CHIP_A, OPC_CHIP_B: begin
            if (s.write_enable_latch && s.op == OP_IDLE) begin
              if (opc == OPC_CHIP_A || opc == OPC_CHIP_B) begin
                next_s.write_enable_latch = 1'b0;
                if (s.bp[3:0] != 4'h0) begin
                  next_s.ee = 1'b1;
                end else begin
                  next_s.ee    = 1'b0;
                  next_s.op    = OP_ERASE;
                  next_s.start = 1'b1;
                  next_s.kind  = KIND_CHIP;
                  next_s.addr  = '0;
                end
              end else if (need_addr) begin
                next_s.write_enable_latch = 1'b0;
                if (hit) begin
                  // refused: region stays read-only
                  if (opc == OPC_PROG) begin
                    next_s.pe = 1'b1;
                  end else begin
                    next_s.ee = 1'b1;
                  end
                end else begin
                  next_s.start = 1'b1;
                  next_s.addr  = tgt;
                  if (opc == OPC_PROG) begin
                    next_s.op   = OP_PROG;
                    next_s.pe   = 1'b0;
                    next_s.kind = KIND_PROG;
                  end else begin
                    next_s.op = OP_ERASE;
                    next_s.ee = 1'b0;
                    if (opc == OPC_SECT) begin
                      next_s.kind = KIND_SECT;
                    end else if (opc == OPC_BLK64) begin
                      next_s.kind = KIND_BLK64;
                    end else begin
                      next_s.kind = KIND_BLK32;
                    end
                  end
                end
              end
            end
          end
          default: begin
          end
        endcase
      end
    end

    // reset pin: volatile bits return to power-up state
    if (!s.rp_sync[1]) begin
      next_s.write_enable_latch       = 1'b0;
      next_s.sus_e     = 1'b0;
      next_s.sus_p     = 1'b0;
      next_s.pe        = 1'b0;
      next_s.ee        = 1'b0;
      next_s.address_mode_flag       = s.powerup_address_mode;
      next_s.asleep    = 1'b0;
      next_s.rst_armed = 1'b0;
      next_s.op        = OP_IDLE;
      next_s.start     = 1'b0;
    end
    next_s.susp = next_s.sus_e || next_s.sus_p;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s          <= '0;
      s.cs_sync  <= 3'h7;
      s.wp_sync  <= 2'h3;
      s.rp_sync  <= 2'h3;
      s.status_lock_low     <= RST_SRP[0];
      s.status_lock_high     <= RST_SRP[1];
      s.bp       <= RST_BP;
      s.lb       <= RST_LB;
      s.qe       <= RST_QE;
      s.hold_rst <= RST_HR;
      s.drv      <= RST_DRV;
      s.powerup_address_mode      <= RST_ADP;
      s.address_mode_flag      <= RST_ADP;
      s.dc       <= RST_DC;
      s.write_enable_latch      <= 1'b0;
      s.op       <= OP_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign array_start   = s.start;
  assign array_kind    = s.kind;
  assign array_addr    = s.addr;
  assign array_suspend = s.susp;

endmodule : fwp_top

//--- tb/fwp_chk.sv
// Purpose: port assertions for fwp_top
// Assumes: one mclk domain, sys_rst async high
// Notes:   attached by bind at the foot
`timescale 1ns/1ps
module fwp_chk
  import fwp_pkg::*;
(
  input wire logic              mclk,
  input wire logic              sys_rst,
  input wire logic              cs_n,
  input wire logic              rst_pin_n,
  input wire logic              so_oe_n,
  input wire logic              array_start,
  input wire logic [2:0]        array_kind,
  input wire logic [ADDR_W-1:0] array_addr,
  input wire logic              array_suspend
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_oe_idle; cs_n && $past(cs_n) |-> so_oe_n; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("so driven while deselected");
  property p_start_cs; array_start |-> cs_n && $past(cs_n, 2); endproperty
  a_start_cs: assert property (p_start_cs) else $error("start inside a frame");
  property p_kind; array_start |-> array_kind <= KIND_CHIP; endproperty
  a_kind: assert property (p_kind) else $error("bad kind");
  property p_chip_addr; array_start && array_kind == KIND_CHIP |-> array_addr == 25'h0; endproperty
  a_chip_addr: assert property (p_chip_addr) else $error("chip erase address");
  property p_gap; array_start |=> !array_start [*8]; endproperty
  a_gap: assert property (p_gap) else $error("starts too close");
  property p_rst_quiet; $fell(sys_rst) |-> !array_start [*3]; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("start after reset");
  property p_susp; array_suspend |-> !array_start; endproperty
  a_susp: assert property (p_susp) else $error("start while suspended");
  property p_pin_rst; !rst_pin_n [*5] |-> !array_suspend; endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("reset pin kept suspend");
endmodule : fwp_chk

bind fwp_top fwp_chk u_fwp_chk (.mclk(mclk), .sys_rst(sys_rst), .cs_n(cs_n), .rst_pin_n(rst_pin_n),
  .so_oe_n(so_oe_n), .array_start(array_start), .array_kind(array_kind), .array_addr(array_addr),
  .array_suspend(array_suspend));

//--- tb/fwp_host.sv
// Purpose: host side of the serial link
// Assumes: mode 0, 64 ns link clock, idle low between frames
// Notes:   a released so line reads as pulled up
`timescale 1ns/1ps
module fwp_host (
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so_out,
  input  wire logic so_oe_n
);
  logic [7:0] rd_byte;
  event       rd_done;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  task automatic xfer(input logic [39:0] tx, input int nb, input logic rd);
    cs_n = 1'b0;
    #13;
    for (int i = 0; i < nb; i++) begin
      si = tx[39-i];
      #32;
      sclk = 1'b1;
      rd_byte = {rd_byte[6:0], so_oe_n ? 1'b1 : so_out};
      #32;
      sclk = 1'b0;
    end
    #20;
    cs_n = 1'b1;
    si = ~si;
    if (rd) ->rd_done;
    #90;
  endtask : xfer
endmodule : fwp_host

//--- tb/fwp_top_tb_top.sv
// Purpose: self-checking bench for fwp_top
// Assumes: status write busy shortened to 8 cycles
// Notes:   status bytes and array starts checked from queues
`timescale 1ns/1ps
module fwp_top_tb_top;
  import fwp_pkg::*;
  logic              mclk, sys_rst, wp_n, rst_pin_n, array_done, array_fail;
  logic              sclk, cs_n, si, so_out, so_oe_n, array_start, array_suspend;
  logic              eng_busy, ee, acc;
  logic [2:0]        array_kind;
  logic [ADDR_W-1:0] array_addr, a;
  logic [4:0]        bp;
  logic [7:0]        q_rd[$];
  logic [27:0]       q_st[$];
  int                n_fail, n_checks;
  fwp_top #(.SRW_WAIT(8)) u_fwp_top (.mclk(mclk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .si(si),
    .wp_n(wp_n), .rst_pin_n(rst_pin_n), .array_done(array_done), .array_fail(array_fail), .so_out(so_out),
    .so_oe_n(so_oe_n), .array_start(array_start), .array_kind(array_kind), .array_addr(array_addr),
    .array_suspend(array_suspend));
  fwp_host u_fwp_host (.sclk(sclk), .cs_n(cs_n), .si(si), .so_out(so_out), .so_oe_n(so_oe_n));
  always #4 mclk = ~mclk;
  task automatic chk8(input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH status exp %h got %h", e, s);
    end
  endtask : chk8
  task automatic chkst(input logic [27:0] e, input logic [27:0] s);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH start exp %h got %h", e, s);
    end
  endtask : chkst
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  task automatic cmd(input logic [7:0] op);
    u_fwp_host.xfer({op, 32'h0}, 8, 1'b0);
  endtask : cmd
  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    cmd(OPC_WRITE_ENABLE_CMD_EN);
    u_fwp_host.xfer({op, d, 24'h0}, 16, 1'b0);
  endtask : wr
  task automatic rd(input logic [7:0] op, input logic [7:0] e);
    q_rd.push_back(e);
    u_fwp_host.xfer({op, 32'h0}, 16, 1'b1);
  endtask : rd
  function automatic int lim(logic [4:0] b);
    return (b[3:0] == 4'h0) ? 0 : (1 << (b[3:0] - 4'h1));
  endfunction : lim
  function automatic logic prot(logic [4:0] b, logic [ADDR_W-1:0] ad);
    if ((b[3] && b[1]) || b[3:1] == 3'b110) return 1'b1;
    return b[4] ? (int'(ad[24:16]) < lim(b)) : (int'(ad[24:16]) >= 512 - lim(b));
  endfunction : prot
  task automatic erase(input logic chip);
    acc = chip ? (bp[3:0] == 4'h0) : !prot(bp, a);
    cmd(OPC_WRITE_ENABLE_CMD_EN);
    if (acc) q_st.push_back({chip ? KIND_CHIP : KIND_SECT, chip ? 25'h0 : a});
    u_fwp_host.xfer(chip ? {OPC_CHIP_A, 32'h0} : {OPC_SECT, 7'h0, a}, chip ? 8 : 40, 1'b0);
    rd(OPC_RD_SR1, {1'b0, bp, 1'b0, acc});
    if (!acc) ee = 1'b1;
    wait (!eng_busy);
    rd(OPC_RD_SR3, {4'h2, ee, 3'h0});
  endtask : erase
  // engine answers each start after a fixed delay
  always @(posedge mclk) begin
    if (array_start === 1'b1) begin
      chkst(q_st.pop_front(), {array_kind, array_addr});
      eng_busy = 1'b1;
      repeat (300) @(posedge mclk);
      #1;
      array_done = 1'b1;
      array_fail = 1'($urandom_range(1, 0));
      @(posedge mclk);
      #1;
      array_done = 1'b0;
      ee = array_fail;
      eng_busy = 1'b0;
    end
  end
  always @(u_fwp_host.rd_done) chk8(q_rd.pop_front(), u_fwp_host.rd_byte);
  initial begin
    #500us;
    n_fail++;
    results();
  end
  initial begin
    {mclk, array_done, array_fail, ee, eng_busy, bp} = '0;
    {sys_rst, wp_n, rst_pin_n} = 3'h7;
    void'($urandom(32'h145f));
    repeat (10) @(posedge mclk);
    #1 sys_rst = 1'b0;
    repeat (8) @(posedge mclk);
    rd(OPC_RD_SR1, 8'h00);
    rd(OPC_RD_SR3, 8'h20);
    cmd(OPC_WRITE_ENABLE_CMD_EN);
    rd(OPC_RD_SR1, 8'h02);
    cmd(OPC_WR_DIS);
    rd(OPC_RD_SR1, 8'h00);
    cmd(OPC_ADDR4_ON);
    rd(OPC_RD_SR2, 8'h01);
    u_fwp_host.xfer({OPC_SECT, 32'h0}, 40, 1'b0);
    wr(OPC_WR_SR2, 8'h08);
    wr(OPC_WR_SR2, 8'h85);
    rd(OPC_RD_SR2, 8'h09);
    wr(OPC_WR_SR1, 8'h80);
    @(posedge mclk) #1 wp_n = 1'b0;
    wr(OPC_WR_SR1, 8'h84);
    rd(OPC_RD_SR1, 8'h80);
    @(posedge mclk) #1 wp_n = 1'b1;
    wr(OPC_WR_SR1, 8'h00);
    rd(OPC_RD_SR1, 8'h00);
    for (int k = 0; k < 14; k++) begin
      bp = 5'($urandom);
      wr(OPC_WR_SR1, {1'b0, bp, 2'h0});
      a = ADDR_W'($urandom);
      if (k[0]) a[24:16] = 9'((bp[4] ? lim(bp) : 512 - lim(bp)) - k[1]);
      erase(k % 5 == 4);
    end
    cmd(OPC_SLEEP);
    cmd(OPC_WRITE_ENABLE_CMD_EN);
    rd(OPC_RD_SR1, 8'hff);
    cmd(OPC_WAKE);
    rd(OPC_RD_SR1, {1'b0, bp, 2'h0});
    cmd(OPC_WRITE_ENABLE_CMD_EN);
    cmd(OPC_RST_EN);
    cmd(OPC_RST_GO);
    rd(OPC_RD_SR1, {1'b0, bp, 2'h0});
    rd(OPC_RD_SR2, 8'h08);
    cmd(OPC_ADDR4_ON);
    bp = 5'h00;
    wr(OPC_WR_SR1, 8'h00);
    erase(1'b1);
    cmd(OPC_WRITE_ENABLE_CMD_EN);
    q_st.push_back({KIND_SECT, a});
    u_fwp_host.xfer({OPC_SECT, 7'h0, a}, 40, 1'b0);
    cmd(OPC_SUSPEND);
    rd(OPC_RD_SR2, 8'h89);
    chk8(8'h01, {7'h0, array_suspend});
    @(posedge mclk) #1 rst_pin_n = 1'b0;
    repeat (6) @(posedge mclk);
    #1 rst_pin_n = 1'b1;
    rd(OPC_RD_SR2, 8'h08);
    chk8(8'h00, {7'h0, array_suspend});
    wait (!eng_busy);
    chk8(8'h00, 8'(q_st.size() + q_rd.size()));
    results();
  end
endmodule : fwp_top_tb_top
